// file: common/poll_pkg.sv
// Shared constants and carriers for the polling and bit-check controller.
// Assumes a single 100 MHz system clock; the crystal tick arrives as a pin.
package poll_pkg;
	localparam int base_div = 14;
	localparam int sleep_unit = 1024;
	localparam int stretch_big = 8;
	localparam logic [4:0] idle_forever = 5'h1f;
	localparam int startup_xticks = 16;
	localparam logic [5:0] interval_max = 6'h3f;

	typedef struct packed {
		logic [1:0] rate_band_select;
		logic [4:0] idle_period;
		logic sleep_stretch_select;
		logic [1:0] check_bits_sel;
		logic [4:0] window_lo;
		logic [4:0] window_hi;
	} operating_config_register_t;

	typedef enum logic [2:0] {
		st_sleep = 3'b000,
		st_startup = 3'b001,
		st_check = 3'b011,
		st_receive = 3'b010
	} poll_state_t;

	function automatic logic [4:0] checks_for(input logic [1:0] sel);
		return {2'b00, sel, 1'b0} + {1'b0, sel, 2'b00};
	endfunction
endpackage

// file: hw/polling_bit_check_controller.sv
// Sleep, start-up and bit-check sequencer of a polled receiver.
// Assumes a crystal clock pin and a demodulator data pin, both asynchronous to clk_in.
`timescale 1ns/1ps
// Behaviour
// RULE1: Base tick is the crystal frequency divided by fourteen.
// RULE2: Derived tick is 8, 4, 2 or 1 base ticks for bands 0 to 3.
// RULE3: Polling loops sleep, start-up, bit check; a failed check returns to sleep.
// RULE4: Processing is off during sleep and enabled to settle during start-up.
// RULE5: Active indicator shows sleeping versus active.
// RULE6: Sleep lasts idle value times stretch times 1024 base ticks.
// RULE7: Stretch factor is 8 when stretch select is one, else 1.
// RULE8: Idle value 31 keeps the device asleep until reprogrammed.
// RULE9: Start-up length follows the rate band and the base tick.
// RULE10: Checked bits 0, 3, 6 or 9 give 0, 6, 12 or 18 checks.
// RULE11: Intervals inside the window continue; outside ends the check to sleep.
// RULE12: Enough consecutive passing checks switch to receiving mode.
// RULE13: Low bound is low times tick; high bound is high minus one times tick.
// RULE14: Low and high bounds are separate 5-bit fields.
// RULE15: Host keeps low bound at least 10 and high bound at most 63.
// RULE16: Host should pick 6 or 9 bits when low bound is below 19.
// RULE17: Interval counter runs on derived ticks once checking; start-up data ignored.
// RULE18: Fail on edge below low bound or when count reaches high bound.
// RULE19: Transmitter preburst must cover sleep, start-up, check and host start-up.
// RULE20: Receiving mode holds until explicitly returned to polling.
// RULE21: Poll override low skips sleep and ignores but keeps sleep and check settings.
// RULE22: Zero checked bits go from start-up straight to receiving.
// RULE23: Interval counter restarts from zero at each data edge during check.
module polling_bit_check_controller #(
	parameter int sleep_unit = poll_pkg::sleep_unit,
	parameter int startup_xticks = poll_pkg::startup_xticks
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic crystal_osc_in,
	input wire logic demod_data_in,
	input wire logic poll_override_n_in,
	input wire logic return_to_poll_in,
	input wire poll_pkg::operating_config_register_t cfg_in,
	output logic active_indicator_out,
	output logic signal_enable_out,
	output logic receiving_out,
	output logic check_fail_out
);
	logic [2:0] xo_sync_r;
	logic [2:0] dm_sync_r;
	logic xo_level_r;
	logic dm_level_r;
	logic dm_prev_r;
	logic crystal_edge_r;
	logic base_tick;
	logic derived_tick;
	poll_pkg::poll_state_t state_r;
	logic [18:0] sleep_cnt_r;
	logic [18:0] sleep_len;
	logic [15:0] start_cnt_r;
	logic [5:0] edge_interval_count_r;
	logic [4:0] checks_r;
	logic [4:0] checks_need;
	logic dm_edge;
	logic too_short;
	logic too_long;
	logic override_n;

	function automatic logic is_awake(input poll_pkg::poll_state_t st);
		return st != poll_pkg::st_sleep;
	endfunction

	// Crystal and data pins pass three flops; a change counts once the last two agree.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			xo_sync_r <= 3'h0;
			dm_sync_r <= 3'h0;
			xo_level_r <= 1'b0;
			dm_level_r <= 1'b0;
			crystal_edge_r <= 1'b0;
		end else begin
			xo_sync_r <= {xo_sync_r[1:0], crystal_osc_in};
			dm_sync_r <= {dm_sync_r[1:0], demod_data_in};
			crystal_edge_r <= 1'b0;
			if (xo_sync_r[1] == xo_sync_r[2]) begin
				xo_level_r <= xo_sync_r[2];
				crystal_edge_r <= xo_sync_r[2] & ~xo_level_r;
			end
			if (dm_sync_r[1] == dm_sync_r[2]) begin
				dm_level_r <= dm_sync_r[2];
			end
		end
	end

	tick_divider #(
		.div(poll_pkg::base_div)
	) u_div (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.crystal_edge_in(crystal_edge_r),
		.rate_band_select_in(cfg_in.rate_band_select),
		.base_tick_out(base_tick),
		.derived_tick_out(derived_tick)
	);

	assign override_n = poll_override_n_in;
	// Sleep length in base ticks with the stretch factor. [RULE6] [RULE7]
	assign sleep_len = 19'(cfg_in.idle_period) * 19'(sleep_unit) *
		(cfg_in.sleep_stretch_select ? 19'(poll_pkg::stretch_big) : 19'h1);
	assign checks_need = poll_pkg::checks_for(cfg_in.check_bits_sel); // [RULE10]
	// Data changes are sampled on the derived tick only. [RULE17]
	assign dm_edge = derived_tick && (dm_level_r != dm_prev_r);
	assign too_short = dm_edge && (edge_interval_count_r + 6'h1 < {1'b0, cfg_in.window_lo}); // [RULE13] [RULE14]
	assign too_long = derived_tick &&
		(edge_interval_count_r + 6'h1 >= {1'b0, cfg_in.window_hi}); // [RULE18]

	// Main mode sequencer.
	always_ff @(posedge clk_in) begin
		check_fail_out <= 1'b0;
		if (rst_in) begin
			state_r <= poll_pkg::st_sleep;
		end else begin
			unique case (state_r)
				poll_pkg::st_sleep: begin
					if (!override_n) begin
						state_r <= poll_pkg::st_startup; // [RULE21]
					end else if (cfg_in.idle_period != poll_pkg::idle_forever &&
						sleep_cnt_r >= sleep_len) begin
						state_r <= poll_pkg::st_startup; // [RULE3] [RULE8]
					end
				end
				poll_pkg::st_startup: begin
					if (derived_tick && start_cnt_r >= 16'(startup_xticks - 1)) begin
						if (!override_n || checks_need == 5'h0) begin
							state_r <= poll_pkg::st_receive; // [RULE22] [RULE21]
						end else begin
							state_r <= poll_pkg::st_check; // [RULE3]
						end
					end
				end
				poll_pkg::st_check: begin
					if (too_short || too_long) begin
						state_r <= poll_pkg::st_sleep; // [RULE11] [RULE3]
						check_fail_out <= 1'b1;
					end else if (dm_edge && checks_r + 5'h1 >= checks_need) begin
						state_r <= poll_pkg::st_receive; // [RULE12]
					end
				end
				poll_pkg::st_receive: begin
					if (return_to_poll_in) begin
						state_r <= poll_pkg::st_sleep; // [RULE20]
					end
				end
			endcase
		end
	end

	// Sleep timer counts base ticks while asleep.
	always_ff @(posedge clk_in) begin
		if (rst_in || state_r != poll_pkg::st_sleep) begin
			sleep_cnt_r <= 19'h0;
		end else if (base_tick && sleep_cnt_r != 19'h7ffff) begin
			sleep_cnt_r <= sleep_cnt_r + 19'h1; // [RULE6]
		end
	end

	// Start-up timer counts derived ticks, so its length follows the band. [RULE9]
	always_ff @(posedge clk_in) begin
		if (rst_in || state_r != poll_pkg::st_startup) begin
			start_cnt_r <= 16'h0;
		end else if (derived_tick) begin
			start_cnt_r <= start_cnt_r + 16'h1;
		end
	end

	// Interval counter and check tally.
	always_ff @(posedge clk_in) begin
		if (rst_in || state_r != poll_pkg::st_check) begin
			edge_interval_count_r <= 6'h0;
			checks_r <= 5'h0;
			dm_prev_r <= dm_level_r;
		end else if (derived_tick) begin
			dm_prev_r <= dm_level_r;
			if (dm_edge) begin
				edge_interval_count_r <= 6'h0; // [RULE23]
				checks_r <= checks_r + 5'h1;
			end else if (edge_interval_count_r != poll_pkg::interval_max) begin
				edge_interval_count_r <= edge_interval_count_r + 6'h1; // [RULE17]
			end
		end
	end

	// Outputs from flops.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			active_indicator_out <= 1'b0;
			signal_enable_out <= 1'b0;
			receiving_out <= 1'b0;
		end else begin
			active_indicator_out <= is_awake(state_r); // [RULE5]
			signal_enable_out <= is_awake(state_r); // [RULE4]
			receiving_out <= (state_r == poll_pkg::st_receive);
		end
	end

	// Power and indicator outputs follow the mode one cycle later.
	chk_sleep_disabled: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE4]
		(state_r == poll_pkg::st_sleep)
		|=> !signal_enable_out)
		else $error("signal path enabled in sleep");
	chk_wake_enables: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE4]
		(state_r == poll_pkg::st_startup)
		|=> signal_enable_out)
		else $error("signal path disabled in start-up");
	chk_active_shows: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
		(state_r == poll_pkg::st_check)
		|=> active_indicator_out)
		else $error("active indicator low while checking");
	chk_sleep_shows: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
		(state_r == poll_pkg::st_sleep)
		|=> !active_indicator_out)
		else $error("active indicator high while asleep");
	chk_receive_flag: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE12]
		(state_r == poll_pkg::st_receive)
		|=> receiving_out)
		else $error("receiving flag low in receiving mode");

	// Mode sequencing.
	chk_sleep_next: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
		(state_r == poll_pkg::st_sleep)
		|=> (state_r == poll_pkg::st_sleep || state_r == poll_pkg::st_startup))
		else $error("sleep left for a mode other than start-up");
	chk_startup_next: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
		(state_r == poll_pkg::st_startup)
		|=> state_r != poll_pkg::st_sleep)
		else $error("start-up fell back to sleep");
	chk_check_next: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
		(state_r == poll_pkg::st_check)
		|=> state_r != poll_pkg::st_startup)
		else $error("bit check went back to start-up");
	chk_forever_sleep: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE8]
		(state_r == poll_pkg::st_sleep && override_n && cfg_in.idle_period == poll_pkg::idle_forever)
		|=> state_r == poll_pkg::st_sleep)
		else $error("left permanent sleep");
	chk_sleep_waits: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE6]
		(state_r == poll_pkg::st_sleep && override_n && sleep_cnt_r < sleep_len)
		|=> state_r == poll_pkg::st_sleep)
		else $error("sleep ended early");
	chk_sleep_expires: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE6]
		(state_r == poll_pkg::st_sleep && cfg_in.idle_period != poll_pkg::idle_forever && sleep_cnt_r >= sleep_len)
		|=> state_r == poll_pkg::st_startup)
		else $error("sleep did not end on time");
	chk_startup_waits: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE9]
		(state_r == poll_pkg::st_startup && !(derived_tick && start_cnt_r >= 16'(startup_xticks - 1)))
		|=> state_r == poll_pkg::st_startup)
		else $error("start-up ended early");
	chk_override_wake: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE21]
		(state_r == poll_pkg::st_sleep && !override_n)
		|=> state_r == poll_pkg::st_startup)
		else $error("override did not wake");
	chk_override_receive: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE21]
		(state_r == poll_pkg::st_startup && !override_n && derived_tick && start_cnt_r >= 16'(startup_xticks - 1))
		|=> state_r == poll_pkg::st_receive)
		else $error("override start-up did not reach receiving mode");
	chk_zero_checks: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE22]
		(state_r == poll_pkg::st_startup && checks_need == 5'h0)
		|=> state_r != poll_pkg::st_check)
		else $error("zero checks entered bit check");
	chk_receive_holds: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE20]
		(state_r == poll_pkg::st_receive && !return_to_poll_in)
		|=> state_r == poll_pkg::st_receive)
		else $error("receiving mode dropped");

	// Interval counter and window decisions.
	chk_entry_cleared: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
		(state_r == poll_pkg::st_startup)
		|=> (edge_interval_count_r == 6'h0 && checks_r == 5'h0))
		else $error("interval counter not cleared before check");
	chk_count_steps: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
		(state_r == poll_pkg::st_check && derived_tick && !dm_edge && edge_interval_count_r != poll_pkg::interval_max)
		|=> edge_interval_count_r == $past(edge_interval_count_r) + 6'h1)
		else $error("interval counter missed a derived tick");
	chk_count_idle: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
		(state_r == poll_pkg::st_check && !derived_tick)
		|=> $stable(edge_interval_count_r))
		else $error("interval counter moved between derived ticks");
	chk_counter_restart: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE23]
		(state_r == poll_pkg::st_check && dm_edge && !too_short)
		|=> edge_interval_count_r == 6'h0)
		else $error("interval count not restarted");
	chk_short_fails: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
		(state_r == poll_pkg::st_check && too_short)
		|=> (state_r == poll_pkg::st_sleep && check_fail_out))
		else $error("short interval not failed");
	chk_long_fails: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE18]
		(state_r == poll_pkg::st_check && derived_tick && edge_interval_count_r + 6'h1 >= {1'b0, cfg_in.window_hi})
		|=> state_r == poll_pkg::st_sleep)
		else $error("long interval not failed");
	chk_pass_receives: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE12]
		(state_r == poll_pkg::st_check && dm_edge && !too_short && !too_long && checks_r + 5'h1 >= checks_need)
		|=> state_r == poll_pkg::st_receive)
		else $error("passed check count did not reach receiving mode");
	chk_fail_single: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
		check_fail_out
		|=> !check_fail_out)
		else $error("check failure pulse longer than one cycle");
	chk_fail_to_sleep: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
		check_fail_out
		|-> state_r == poll_pkg::st_sleep)
		else $error("failed check did not return to sleep");
endmodule

// file: hw/tick_divider.sv
// Divider that makes the base tick and the rate-band derived tick.
// Assumes crystal_edge_in is a one-cycle pulse per crystal period, in clk_in domain.
`timescale 1ns/1ps
module tick_divider #(
	parameter int div = poll_pkg::base_div
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic crystal_edge_in,
	input wire logic [1:0] rate_band_select_in,
	output logic base_tick_out,
	output logic derived_tick_out
);
	logic [3:0] div_r;
	logic [2:0] xdiv_r;
	logic [2:0] xmask;

	assign xmask = (rate_band_select_in == 2'h0) ? 3'h7 : (rate_band_select_in == 2'h1) ? 3'h3 :
		(rate_band_select_in == 2'h2) ? 3'h1 : 3'h0;

	// Divides crystal edges by fourteen. [RULE1]
	always_ff @(posedge clk_in) begin
		base_tick_out <= 1'b0;
		if (rst_in) begin
			div_r <= 4'h0;
		end else if (crystal_edge_in) begin
			if (div_r == 4'(div - 1)) begin
				div_r <= 4'h0;
				base_tick_out <= 1'b1;
			end else begin
				div_r <= div_r + 4'h1;
			end
		end
	end

	// Derived tick every 8, 4, 2 or 1 base ticks. [RULE2]
	always_ff @(posedge clk_in) begin
		derived_tick_out <= 1'b0;
		if (rst_in) begin
			xdiv_r <= 3'h0;
		end else if (base_tick_out) begin
			if ((xdiv_r & xmask) == xmask) begin
				xdiv_r <= 3'h0;
				derived_tick_out <= 1'b1;
			end else begin
				xdiv_r <= xdiv_r + 3'h1;
			end
		end
	end

	chk_base_from_crystal: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
		base_tick_out
		|-> $past(crystal_edge_in))
		else $error("base tick without crystal edge");
	chk_derived_from_base: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE2]
		derived_tick_out
		|-> $past(base_tick_out))
		else $error("derived tick without base tick");
endmodule

// file: test/far_side_model.sv
// Far-side model: crystal oscillator and remote transmitter behind the demodulator.
// Assumes run_in is the receiver's active indicator and tick_cycles_in one derived tick in clk_in cycles.
`timescale 1ns/1ps
module far_side_model (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic [7:0] half_ticks_in,
	input wire logic [15:0] tick_cycles_in,
	output logic crystal_osc_out,
	output logic demod_data_out
);
	int xcnt = 0;
	int dcnt = 0;
	initial begin
		crystal_osc_out = 1'b0;
		demod_data_out = 1'b0;
	end
	// Free-running crystal square wave of eight system cycles.
	always @(negedge clk_in) begin
		xcnt <= (xcnt + 1) % 8;
		crystal_osc_out <= (xcnt < 4);
	end
	// Noise while the receiver sleeps; once awake, a steady burst with a fixed half period, or a held level when half_ticks_in is zero.
	always @(negedge clk_in) begin
		if (!run_in) begin
			dcnt <= 0;
			demod_data_out <= ~demod_data_out;
		end else if (half_ticks_in != 8'h00 && dcnt + 1 >= half_ticks_in * tick_cycles_in) begin
			dcnt <= 0;
			demod_data_out <= ~demod_data_out;
		end else begin
			dcnt <= dcnt + 1;
		end
	end
endmodule

// file: test/polling_bit_check_controller_tb.sv
// Self-checking bench for the polling and bit-check controller.
// Assumes the far-side model supplies the crystal and the demodulator data.
`timescale 1ns/1ps
module polling_bit_check_controller_tb;
	localparam int bc = 8 * poll_pkg::base_div;
	logic clk_in;
	logic rst_in;
	logic xtal;
	logic data;
	logic override_n;
	logic ret_req;
	logic active_indicator_out;
	logic signal_enable_out;
	logic receiving_out;
	logic check_fail_out;
	logic [7:0] half;
	poll_pkg::operating_config_register_t cfg;
	int n_errors = 0;
	int n_tests = 0;
	int n_fail = 0;
	int cycles = 0;
	int c;

	polling_bit_check_controller #(.sleep_unit(1), .startup_xticks(2)) dut (.clk_in(clk_in), .rst_in(rst_in),
		.crystal_osc_in(xtal), .demod_data_in(data), .poll_override_n_in(override_n), .return_to_poll_in(ret_req),
		.cfg_in(cfg), .active_indicator_out(active_indicator_out), .signal_enable_out(signal_enable_out),
		.receiving_out(receiving_out), .check_fail_out(check_fail_out));
	far_side_model far (.clk_in(clk_in), .run_in(active_indicator_out), .half_ticks_in(half),
		.tick_cycles_in(16'(bc)), .crystal_osc_out(xtal), .demod_data_out(data));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (check_fail_out === 1'b1) n_fail++;
		if (cycles == 95000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	function automatic bit hit(input int which);
		case (which)
			0: return active_indicator_out === 1'b1;
			1: return active_indicator_out === 1'b0;
			2: return receiving_out === 1'b1;
			default: return check_fail_out === 1'b1;
		endcase
	endfunction
	// Counts cycles until the chosen output condition holds; gives -1 when the limit runs out.
	task automatic wait_sig(input int which, input int lim, output int cyc);
		cyc = 0;
		while (cyc < lim && !hit(which)) begin
			@(negedge clk_in);
			cyc++;
		end
		if (cyc >= lim) cyc = -1;
	endtask
	task automatic ret();
		@(negedge clk_in);
		ret_req = 1'b1;
		@(negedge clk_in);
		ret_req = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic fail_case(input logic [7:0] h, input int lo, input int hi);
		half = h;
		wait_sig(0, 3000, c);
		wait_sig(3, 3000, c);
		chk_rng("fail_time", lo * bc, hi * bc, c);
		repeat (3) @(negedge clk_in);
		chk("active_after_fail", 0, active_indicator_out);
		chk("enable_after_fail", 0, signal_enable_out);
	endtask

	initial begin
		rst_in = 1'b1;
		override_n = 1'b1;
		ret_req = 1'b0;
		half = 8'h0e;
		cfg = '{2'h3, 5'h02, 1'b0, 2'h2, 5'h0a, 5'h14};
		repeat (10) @(negedge clk_in);
		rst_in = 1'b0;
		chk("active_indicator", 0, active_indicator_out);
		for (int s = 2; s <= 3; s++) begin
			cfg.check_bits_sel = 2'(s);
			n_fail = 0;
			wait_sig(0, 4000, c);
			chk("signal_enable", 1, signal_enable_out);
			wait_sig(2, 40000, c);
			chk_rng("check_time", (84 * s - 1) * bc, (84 * s + 1) * bc, c);
			chk("fail_pulses", 0, n_fail);
			repeat (300) @(negedge clk_in);
			chk("receiving_held", 1, receiving_out);
			ret();
			wait_sig(1, 5, c);
			chk("receiving_released", 0, receiving_out);
		end
		fail_case(8'h00, 19, 23);
		fail_case(8'h09, 8, 10);
		cfg.idle_period = 5'h1f;
		half = 8'h0e;
		wait_sig(0, 3000, c);
		chk("sleep_forever", 32'hffffffff, c);
		override_n = 1'b0;
		wait_sig(2, 1000, c);
		chk_rng("override_time", 1, 4 * bc, c);
		override_n = 1'b1;
		ret();
		wait_sig(0, 3000, c);
		chk("settings_kept", 32'hffffffff, c);
		cfg.idle_period = 5'h01;
		cfg.check_bits_sel = 2'h0;
		wait_sig(2, 3000, c);
		for (int b = 0; b < 4; b++) begin
			cfg.rate_band_select = 2'(b);
			cfg.sleep_stretch_select = b[0];
			ret();
			wait_sig(0, 3000, c);
			chk_rng("sleep_time", b[0] ? 7 * bc : 1, (b[0] ? 9 : 2) * bc, c);
			wait_sig(2, 5000, c);
			chk_rng("startup_time", (8 >> b) * bc, (16 >> b) * bc + bc, c);
		end
		give_verdict();
	end
endmodule
